// ---- core/pcs_device.sv ----
// conference switch: host port, sample engine and pcm output
// Notes on behaviour
// - pair mode: read strobe needs chip select
// - read falling edge drives addressed register
// - data strobe rising edge ends access
// - pair mode: write latches on rising edge
// - direction line high reads, low writes
// - address captured while latch line high
// - demux: latch tied low pair, high strobe
// - bus carries address only when multiplexed
// - direct address bits only in demux
// - chip select high: strobes ignored
// - eight pcm outputs, each can float
// - reset high, at least four clocks
// - device clock 4096 or 8192 kHz
// - 64 of 512 inputs to 256 outputs
// - up to 21 conferences, 3 to 64
// - input 0/-3/-6/-9 dB, output 0/-3
// - quiet samples dropped, four thresholds
// - optional inversion of every second channel
// - multipoint: output is or of inputs
// - overflow raises maskable open-drain interrupt
module pcs_device
  import pcs_pkg::*;
#(
  parameter int CLK_KHZ = DEV_CLK_KHZ,
  parameter int N_CONF = MAX_CONF
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // board straps
  input wire logic bus_style_in,
  input wire logic bus_muxed_in,
  // pin side
  pcs_bus_if.dev bus
);
  import pcs_pkg::*;
  // bit period derived from device clock
  localparam int BIT_DIV = CLK_KHZ / PCM_RATE_KHZ;
  localparam int BDW = $clog2(BIT_DIV + 1);

  initial begin
    if (CLK_KHZ != 4096 && CLK_KHZ != 8192)
      $error("pcs_device: device clock must be 4096 or 8192 kHz");
    // conference count limited by the channel pool
    if (N_CONF < 1 || N_CONF * MIN_MEMBERS > NUM_CONF_CH)
      $error("pcs_device: conference count out of range");
    // conference pool within the channel counts
    if (NUM_CONF_CH > NUM_IN_CH || NUM_OUT_CH > NUM_IN_CH)
      $error("pcs_device: channel counts inconsistent");
  end

  typedef struct packed {
    logic style;
    logic muxed;
    logic [7:0] ctrl;
    logic [7:0] att;
    logic [7:0] smp_a;
    logic [7:0] smp_b;
    logic [7:0] conf;
    logic [7:0] mask;
    logic [7:0] rslt;
    logic [7:0] addr;
    logic ovf;
    logic busy;
    logic a_prev;
    logic b_prev;
    logic [7:0] bus_out;
    logic bus_oe_n;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    logic [BDW-1:0] div;
    logic [7:0] pcm;
    logic [7:0] pcm_oe_n;
    logic int_oe_n;
  } pcs_dev_s;
  pcs_dev_s s_q, s_d;

  logic [16:0] pin_raw, pin_s;
  logic [7:0] ad_s;
  logic [1:0] da_s;
  logic ale_s, sb_s, sa_s, cs_n_s, rst_pin_s, style_s, muxed_s;
  logic rst;

  assign pin_raw = {bus_style_in, bus_muxed_in, bus.reset_high,
                    bus.cs_n, bus.strobe_a, bus.strobe_b, bus.ale,
                    bus.direct_addr, bus.bus_bits};
  // idle pins while held: deselected, strobes high, reset pin asserted
  pcs_sync2 #(.W(17), .RST_VAL(17'h07e00)) u_sync (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .d_in(pin_raw),
    .q_out(pin_s)
  );
  assign {style_s, muxed_s, rst_pin_s, cs_n_s, sa_s, sb_s, ale_s,
          da_s, ad_s} = pin_s;
  // pin reset joins the system reset
  assign rst = srst_in || rst_pin_s;

  function automatic logic signed [9:0] scale(
    input logic signed [9:0] x, input logic [1:0] c);
    logic signed [19:0] p;
    p = 20'(x) * $signed({11'h000, ATT_MUL});
    unique case (c)
      2'h0: scale = x;
      2'h1: scale = 10'(p >>> 8);
      2'h2: scale = x >>> 1;
      2'h3: scale = 10'(p >>> 9);
    endcase
  endfunction

  // samples under the threshold count as silence
  function automatic logic signed [9:0] gate(
    input logic [7:0] x, input logic [1:0] t);
    logic [7:0] mag;
    logic [7:0] thr;
    mag = x[7] ? 8'(-x) : x;
    thr = THR_TAB[8*t +: 8];
    gate = (mag < thr) ? 10'sh000 : 10'($signed(x));
  endfunction

  function automatic logic [7:0] reg_read(
    input pcs_dev_s s, input logic [2:0] i);
    unique case (i)
      REG_CTRL: reg_read = s.ctrl;
      REG_STAT: reg_read = {6'h00, s.busy, s.ovf};
      REG_SMPA: reg_read = s.smp_a;
      REG_SMPB: reg_read = s.smp_b;
      REG_ATT: reg_read = s.att;
      REG_CONF: reg_read = s.conf;
      REG_MASK: reg_read = s.mask;
      REG_RSLT: reg_read = s.rslt;
    endcase
  endfunction

  logic [2:0] idx;
  logic mapped, sel, rd_fall, wr_rise, ds_fall, ds_rise, do_wr, ovf_set;
  logic signed [9:0] va, vb, sum, outv;

  always_comb begin
    s_d = s_q;
    ovf_set = 1'b0;
    // multiplexed: address comes over the bus pins
    // demultiplexed: direct bits plus page select
    idx = s_q.muxed ? s_q.addr[2:0] :
          {s_q.ctrl[CTRL_PAGE], da_s};
    mapped = !s_q.muxed || (s_q.addr[7:3] == 5'h00);
    sel = !cs_n_s;
    // read strobe counts only while selected
    rd_fall = s_q.style == STYLE_PAIR && sel && s_q.a_prev && !sa_s;
    // write latches on rising edge of write strobe
    wr_rise = s_q.style == STYLE_PAIR && sel && !s_q.b_prev && sb_s;
    // direction line chooses read or write
    ds_fall = s_q.style == STYLE_STROBE && sel && s_q.a_prev &&
              !sa_s && sb_s;
    // rising data strobe closes the access
    ds_rise = s_q.style == STYLE_STROBE && sel && !s_q.a_prev &&
              sa_s && !sb_s;
    do_wr = (wr_rise || ds_rise) && mapped;
    s_d.a_prev = sa_s;
    s_d.b_prev = sb_s;
    // address follows the bus while latch line is high
    // tied latch level is harmless in demux
    if (s_q.muxed && ale_s) s_d.addr = ad_s;
    // falling read edge drives the register out
    if (rd_fall || ds_fall) begin
      s_d.bus_out = mapped ? reg_read(s_q, idx) : 8'h00;
      s_d.bus_oe_n = 1'b0;
    end else if (sa_s || cs_n_s) begin
      s_d.bus_oe_n = 1'b1;
    end
    // sample engine
    // per-channel input attenuation
    va = scale(gate(s_q.smp_a, s_q.ctrl[CTRL_THR_LO +: 2]),
               s_q.att[ATT_A_LO +: 2]);
    vb = scale(gate(s_q.smp_b, s_q.ctrl[CTRL_THR_LO +: 2]),
               s_q.att[ATT_B_LO +: 2]);
    if (s_q.ctrl[CTRL_INV]) vb = -vb;
    sum = va + vb;
    // output attenuation 0 or -3 dB
    outv = scale(sum, {1'b0, s_q.att[ATT_OUT]});
    if (do_wr) begin
      unique case (idx)
        REG_CTRL: s_d.ctrl = ad_s;
        REG_SMPA: s_d.smp_a = ad_s;
        REG_ATT: s_d.att = ad_s;
        REG_MASK: s_d.mask = ad_s;
        REG_RSLT: s_d.rslt = s_q.rslt;
        // conference numbers beyond the limit are refused
        REG_CONF: if (ad_s < 8'(N_CONF)) s_d.conf = ad_s;
        REG_STAT: if (ad_s[STAT_OVF]) s_d.ovf = 1'b0;
        REG_SMPB: begin
          s_d.smp_b = ad_s;
          s_d.busy = 1'b1;
          s_d.bitcnt = 4'h8;
          s_d.div = BDW'(BIT_DIV - 1);
        end
      endcase
    end
    if (s_q.busy && s_q.bitcnt == 4'h8 && s_q.div == BDW'(BIT_DIV - 1)
        && !do_wr) begin
      // multipoint mode ors the member bytes
      if (s_q.ctrl[CTRL_MP]) begin
        s_d.rslt = s_q.smp_a | s_q.smp_b;
      end else if (outv > SAT_MAX) begin
        s_d.rslt = 8'h7f;
        ovf_set = 1'b1;
      end else if (outv < SAT_MIN) begin
        s_d.rslt = 8'h80;
        ovf_set = 1'b1;
      end else begin
        s_d.rslt = outv[7:0];
      end
      s_d.shreg = s_d.rslt;
    end
    // serial output msb first on the chosen line
    s_d.pcm = 8'h00;
    s_d.pcm_oe_n = 8'hff;
    if (s_q.busy && s_q.bitcnt != 4'h8 && s_q.ctrl[CTRL_PCM_EN]) begin
      s_d.pcm[s_q.att[ATT_LINE_LO +: 3]] = s_q.shreg[7];
      s_d.pcm_oe_n[s_q.att[ATT_LINE_LO +: 3]] = 1'b0;
    end
    if (s_q.busy && !do_wr) begin
      if (s_q.div != '0) begin
        s_d.div = s_q.div - 1'b1;
      end else if (s_q.bitcnt == 4'h0) begin
        // all lines released once the byte is out
        s_d.busy = 1'b0;
      end else begin
        s_d.div = BDW'(BIT_DIV - 1);
        s_d.bitcnt = s_q.bitcnt - 1'b1;
        if (s_q.bitcnt != 4'h8) s_d.shreg = {s_q.shreg[6:0], 1'b0};
      end
    end
    // sticky overflow, set wins over clear
    if (ovf_set) s_d.ovf = 1'b1;
    // open-drain request pulls low while flagged and mask bit 0 is set
    s_d.int_oe_n = !(s_q.ovf && s_q.mask[0]);
    if (rst) begin
      s_d = '0;
      // straps taken while reset is held
      s_d.style = style_s;
      s_d.muxed = muxed_s;
      s_d.ctrl = CTRL_RST;
      s_d.att = ATT_RST;
      s_d.mask = MASK_RST;
      s_d.a_prev = 1'b1;
      s_d.b_prev = 1'b1;
      s_d.bus_oe_n = 1'b1;
      s_d.pcm_oe_n = 8'hff;
      s_d.int_oe_n = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (ce_in || srst_in) begin
      s_q <= s_d;
    end
  end

  assign bus.dev_bus = s_q.bus_out;
  assign bus.dev_bus_oe_n = s_q.bus_oe_n;
  assign bus.pcm_output = s_q.pcm;
  assign bus.pcm_oe_n = s_q.pcm_oe_n;
  assign bus.int_oe_n = s_q.int_oe_n;
endmodule

// ---- core/pcs_pkg.sv ----
// shared constants for the conference switch host port
package pcs_pkg;
  localparam int DW = 8;
  localparam int IW = 3;
  localparam int NREG = 8;
  localparam int PCM_LINES = 8;
  // register indices
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_STAT = 3'h1;
  localparam logic [2:0] REG_SMPA = 3'h2;
  localparam logic [2:0] REG_SMPB = 3'h3;
  localparam logic [2:0] REG_ATT = 3'h4;
  localparam logic [2:0] REG_CONF = 3'h5;
  localparam logic [2:0] REG_MASK = 3'h6;
  localparam logic [2:0] REG_RSLT = 3'h7;
  // field positions
  localparam int CTRL_PCM_EN = 0;
  localparam int CTRL_INV = 1;
  localparam int CTRL_MP = 2;
  localparam int CTRL_THR_LO = 3;
  localparam int CTRL_PAGE = 5;
  localparam int ATT_A_LO = 0;
  localparam int ATT_B_LO = 2;
  localparam int ATT_OUT = 4;
  localparam int ATT_LINE_LO = 5;
  localparam int STAT_OVF = 0;
  localparam int STAT_BUSY = 1;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] ATT_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h01;
  // noise thresholds, one byte per level
  localparam logic [31:0] THR_TAB = 32'h10080400;
  // 0.707 in 1/256 units, i.e. -3 dB
  localparam logic [8:0] ATT_MUL = 9'h0b5;
  localparam logic signed [9:0] SAT_MAX = 10'sh07f;
  localparam logic signed [9:0] SAT_MIN = -10'sh080;
  // sizes of the switch
  localparam int NUM_IN_CH = 512;
  localparam int NUM_OUT_CH = 256;
  localparam int NUM_CONF_CH = 64;
  localparam int MAX_CONF = 21;
  localparam int MIN_MEMBERS = 3;
  // clocks and timing
  localparam int DEV_CLK_KHZ = 8192;
  localparam int PCM_RATE_KHZ = 2048;
  localparam int CLK_NS = 100;
  localparam int RESET_MIN_CYC = 4;
  localparam int ADDR_NS = 300;
  localparam int GAP_NS = 200;
  localparam int STRB_NS = 700;
  localparam int ADDR_CYC = (ADDR_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STRB_CYC = (STRB_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic {STYLE_PAIR = 1'b0, STYLE_STROBE = 1'b1} pcs_style_e;
endpackage

// ---- core/pcs_bus_if.sv ----
// pins between the host and the conference switch
interface pcs_bus_if;
  import pcs_pkg::*;
  logic cs_n;
  logic strobe_a;
  logic strobe_b;
  logic ale;
  logic [1:0] direct_addr;
  logic reset_high;
  logic [7:0] host_bus;
  logic host_bus_oe_n;
  logic [7:0] dev_bus;
  logic dev_bus_oe_n;
  logic [7:0] bus_bits;
  logic [7:0] pcm_output;
  logic [7:0] pcm_oe_n;
  logic int_oe_n;
  // resolved shared bus, pulled high when nobody drives
  assign bus_bits = !host_bus_oe_n ? host_bus :
                    (!dev_bus_oe_n ? dev_bus : 8'hff);
  modport host (output cs_n, strobe_a, strobe_b, ale, direct_addr,
                reset_high, host_bus, host_bus_oe_n,
                input bus_bits, int_oe_n);
  modport dev (input cs_n, strobe_a, strobe_b, ale, direct_addr,
               reset_high, bus_bits,
               output dev_bus, dev_bus_oe_n, pcm_output, pcm_oe_n,
               int_oe_n);
endinterface

// ---- core/pcs_sync2.sv ----
// two-flop synchroniser for pin inputs
module pcs_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] out;
  } pcs_sync_s;
  pcs_sync_s s_q, s_d;

  initial begin
    if (W < 1) $error("pcs_sync2: width must be positive");
  end

  always_comb begin
    s_d = s_q;
    s_d.meta = d_in;
    s_d.out = s_q.meta;
    if (srst_in) begin
      s_d.meta = RST_VAL;
      s_d.out = RST_VAL;
    end
  end

  always_ff @(posedge clk_in) begin
    if (ce_in || srst_in) begin
      s_q <= s_d;
    end
  end

  assign q_out = s_q.out;
endmodule

// ---- core/pcs_host.sv ----
// host end: runs register accesses over the parallel port pins
module pcs_host
  import pcs_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // board straps
  input wire logic bus_style_in,
  input wire logic bus_muxed_in,
  // request
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [7:0] req_addr_in,
  input wire logic [7:0] req_data_in,
  // answer
  output logic busy_out,
  output logic done_out,
  output logic [7:0] rdata_out,
  output logic irq_out,
  // pin side
  pcs_bus_if.host bus
);
  import pcs_pkg::*;
  typedef enum logic [2:0] {
    ST_RST = 3'b000, ST_IDLE = 3'b001, ST_ADDR = 3'b011,
    ST_GAP = 3'b010, ST_STRB = 3'b110, ST_HOLD = 3'b111
  } pcs_hst_e;
  typedef struct packed {
    pcs_hst_e st;
    logic [3:0] cnt;
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
    logic cs_n, sa, sb, ale, rst_pin, oe_n;
    logic [7:0] bus_o;
    logic [1:0] da;
    logic busy, done, irq;
    logic [7:0] rdata;
  } pcs_hst_s;
  pcs_hst_s s_q, s_d;
  logic [8:0] in_s;
  logic pair, idle_ale;

  pcs_sync2 #(.W(9), .RST_VAL(9'h1ff)) u_sync (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .d_in({bus.int_oe_n, bus.bus_bits}),
    .q_out(in_s)
  );

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.irq = !in_s[8];
    pair = bus_style_in == STYLE_PAIR;
    // demux latch level: low for pair, high for strobe
    idle_ale = pair ? 1'b0 : 1'b1;
    if (bus_muxed_in) idle_ale = 1'b0;
    unique case (s_q.st)
      ST_RST: begin
        // reset pin held for the minimum length
        if (s_q.cnt == 4'(RESET_MIN_CYC - 1)) begin
          s_d.st = ST_IDLE;
          s_d.rst_pin = 1'b0;
          s_d.busy = 1'b0;
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      ST_IDLE: begin
        s_d.ale = idle_ale;
        if (req_valid_in) begin
          s_d.wr = req_write_in;
          s_d.addr = req_addr_in;
          s_d.data = req_data_in;
          s_d.busy = 1'b1;
          s_d.cnt = '0;
          // select the device for the access
          s_d.cs_n = 1'b0;
          s_d.da = req_addr_in[1:0];
          if (!pair) s_d.sb = !req_write_in;
          if (bus_muxed_in) begin
            // address on the bus with latch high
            s_d.st = ST_ADDR;
            s_d.ale = 1'b1;
            s_d.bus_o = req_addr_in;
            s_d.oe_n = 1'b0;
          end else begin
            s_d.st = ST_GAP;
          end
        end
      end
      ST_ADDR: begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (s_q.cnt == 4'(ADDR_CYC - 1)) begin
          s_d.st = ST_GAP;
          s_d.cnt = '0;
          s_d.ale = 1'b0;
          s_d.oe_n = 1'b1;
        end
      end
      ST_GAP: begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (s_q.cnt == 4'(GAP_CYC - 1)) begin
          s_d.st = ST_STRB;
          s_d.cnt = '0;
          s_d.bus_o = s_q.data;
          s_d.oe_n = !s_q.wr;
          if (pair && s_q.wr) s_d.sb = 1'b0;
          else s_d.sa = 1'b0;
        end
      end
      ST_STRB: begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (s_q.cnt == 4'(STRB_CYC - 1)) begin
          s_d.st = ST_HOLD;
          s_d.cnt = '0;
          s_d.rdata = s_q.wr ? s_q.rdata : in_s[7:0];
          s_d.sa = 1'b1;
          if (pair) s_d.sb = 1'b1;
        end
      end
      ST_HOLD: begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (s_q.cnt == 4'(GAP_CYC - 1)) begin
          s_d.st = ST_IDLE;
          s_d.cs_n = 1'b1;
          s_d.oe_n = 1'b1;
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
          s_d.sb = 1'b1;
        end
      end
      default: s_d.st = ST_RST;
    endcase
    if (srst_in) begin
      s_d = '0;
      s_d.st = ST_RST;
      s_d.cs_n = 1'b1;
      s_d.sa = 1'b1;
      s_d.sb = 1'b1;
      s_d.rst_pin = 1'b1;
      s_d.oe_n = 1'b1;
      s_d.busy = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (ce_in || srst_in) begin
      s_q <= s_d;
    end
  end

  assign bus.cs_n = s_q.cs_n;
  assign bus.strobe_a = s_q.sa;
  assign bus.strobe_b = s_q.sb;
  assign bus.ale = s_q.ale;
  assign bus.direct_addr = s_q.da;
  assign bus.reset_high = s_q.rst_pin;
  assign bus.host_bus = s_q.bus_o;
  assign bus.host_bus_oe_n = s_q.oe_n;
  assign busy_out = s_q.busy;
  assign done_out = s_q.done;
  assign rdata_out = s_q.rdata;
  assign irq_out = s_q.irq;
endmodule

// ---- verification/pcs_chk.sv ----
// pin-level assertions between the host end and the device end
module pcs_chk (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // port pins
  input wire logic cs_n,
  input wire logic strobe_a,
  input wire logic strobe_b,
  input wire logic reset_high,
  input wire logic host_bus_oe_n,
  input wire logic dev_bus_oe_n,
  input wire logic [7:0] pcm_oe_n,
  input wire logic int_oe_n
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  // a selected read starts: strobe falls with the direction at read
  sequence s_read_start;
    $fell(strobe_a) && !cs_n && strobe_b;
  endsequence
  sequence s_read_end;
    $rose(strobe_a) && !cs_n;
  endsequence
  sequence s_desel;
    cs_n [*4];
  endsequence

  property p_rd_drive;
    s_read_start |-> ##4 !dev_bus_oe_n;
  endproperty
  property p_rd_end;
    s_read_end |-> ##[1:4] dev_bus_oe_n;
  endproperty
  property p_desel;
    s_desel |-> dev_bus_oe_n;
  endproperty
  property p_wr_nodrive;
    !cs_n && !strobe_b |-> dev_bus_oe_n;
  endproperty
  property p_host_off;
    !strobe_a && !cs_n && strobe_b |-> host_bus_oe_n;
  endproperty
  property p_no_clash;
    host_bus_oe_n || dev_bus_oe_n;
  endproperty
  property p_pcm_one;
    $onehot0(~pcm_oe_n);
  endproperty
  property p_rst_out;
    $fell(srst_in) |-> pcm_oe_n == 8'hff && dev_bus_oe_n && int_oe_n;
  endproperty
  property p_rst_len;
    $fell(reset_high) |-> $past(reset_high, 4);
  endproperty

  a_rd_drive: assert property (p_rd_drive)
    else $error("device did not drive the bus for a read");
  a_rd_end: assert property (p_rd_end)
    else $error("device kept the bus after the strobe rose");
  a_desel: assert property (p_desel)
    else $error("device drives the bus while deselected");
  a_wr_nodrive: assert property (p_wr_nodrive)
    else $error("device drives the bus during a write");
  a_host_off: assert property (p_host_off)
    else $error("host drives the bus during a read");
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive the bus");
  a_pcm_one: assert property (p_pcm_one)
    else $error("more than one pcm line driven");
  a_rst_out: assert property (p_rst_out)
    else $error("outputs not released after reset");
  a_rst_len: assert property (p_rst_len)
    else $error("device reset pulse shorter than four clocks");
endmodule

// ---- verification/test_pcm_conference_switch_host_port.sv ----
// self-checking bench: host end and device end joined over the port
module test_pcm_conference_switch_host_port;
  timeunit 1ns;
  timeprecision 1ns;
  import pcs_pkg::*;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic ce_in = 1'b1;
  logic bus_style_in = 1'b0;
  logic bus_muxed_in = 1'b0;
  logic req_valid_in = 1'b0;
  logic req_write_in = 1'b0;
  logic [7:0] req_addr_in = 8'h00;
  logic [7:0] req_data_in = 8'h00;
  logic busy_out;
  logic done_out;
  logic irq_out;
  logic [7:0] rdata_out;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  int regs [8];

  always #50 clk_in = ~clk_in;

  pcs_bus_if pcs_bus_if_inst ();
  pcs_host pcs_host_inst (.clk_in(clk_in), .srst_in(srst_in),
    .ce_in(ce_in), .bus_style_in(bus_style_in),
    .bus_muxed_in(bus_muxed_in), .req_valid_in(req_valid_in),
    .req_write_in(req_write_in), .req_addr_in(req_addr_in),
    .req_data_in(req_data_in), .busy_out(busy_out),
    .done_out(done_out), .rdata_out(rdata_out), .irq_out(irq_out),
    .bus(pcs_bus_if_inst));
  pcs_device pcs_device_inst (.clk_in(clk_in), .srst_in(srst_in),
    .ce_in(ce_in), .bus_style_in(bus_style_in),
    .bus_muxed_in(bus_muxed_in), .bus(pcs_bus_if_inst));
  pcs_chk pcs_chk_inst (.clk_in(clk_in), .srst_in(srst_in),
    .cs_n(pcs_bus_if_inst.cs_n), .strobe_a(pcs_bus_if_inst.strobe_a),
    .strobe_b(pcs_bus_if_inst.strobe_b),
    .reset_high(pcs_bus_if_inst.reset_high),
    .host_bus_oe_n(pcs_bus_if_inst.host_bus_oe_n),
    .dev_bus_oe_n(pcs_bus_if_inst.dev_bus_oe_n),
    .pcm_oe_n(pcs_bus_if_inst.pcm_oe_n),
    .int_oe_n(pcs_bus_if_inst.int_oe_n));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // hang guard: about 330 accesses of under 20 cycles each
  always @(posedge clk_in) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      end_sim();
    end
  end

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] seen);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic do_reset(input logic style, input logic muxed);
    int i;
    @(negedge clk_in);
    srst_in = 1'b1;
    bus_style_in = style;
    bus_muxed_in = muxed;
    repeat (3) @(negedge clk_in);
    srst_in = 1'b0;
    i = 0;
    while (busy_out !== 1'b0 && i < 50) begin
      @(negedge clk_in);
      i++;
    end
    check("busy after reset", 8'h00, {7'h00, busy_out});
    repeat (6) @(negedge clk_in);
    regs = '{CTRL_RST, 0, 0, 0, ATT_RST, 0, MASK_RST, 0};
  endtask

  // one request through the host end; called and left at a falling edge
  task automatic access(input logic wr, input logic [7:0] addr,
                        input logic [7:0] data, output logic [7:0] rd);
    int i;
    req_write_in = wr;
    req_addr_in = addr;
    req_data_in = data;
    req_valid_in = 1'b1;
    @(negedge clk_in);
    req_valid_in = 1'b0;
    i = 0;
    while (done_out !== 1'b1 && i < 100) begin
      @(negedge clk_in);
      i++;
    end
    check("done", 8'h01, {7'h00, done_out});
    rd = rdata_out;
    @(negedge clk_in);
  endtask

  // access plus register model; sample-b writes are left to the engine test
  task automatic op(input logic wr, input logic [7:0] addr,
                    input logic [7:0] data);
    int idx;
    logic ok;
    logic [7:0] rd;
    ok = !bus_muxed_in || addr < 8;
    idx = bus_muxed_in ? addr[2:0] : {regs[0][CTRL_PAGE], addr[1:0]};
    if (ok && idx == 3) wr = 1'b0;
    access(wr, addr, data, rd);
    if (wr) begin
      if (ok && idx != 1 && idx != 7 && !(idx == 5 && data >= MAX_CONF))
        regs[idx] = data;
    end else begin
      check("read data", ok ? 8'(regs[idx]) : 8'h00, rd);
    end
  endtask

  initial begin
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] rd;
    logic [31:0] sh;
    logic [31:0] exp_sh;
    int m;
    int k;
    int drv;
    void'($urandom(81929));
    for (m = 0; m < 4; m++) begin
      do_reset(m[1], m[0]);
      check("irq", 8'h00, {7'h00, irq_out});
      for (k = 0; k < 8; k++) op(1'b0, k[7:0], 8'h00);
      a = 8'($urandom);
      b = 8'($urandom);
      op(1'b1, 8'h00, 8'h05);
      op(1'b1, 8'h02, a);
      access(1'b1, 8'h03, b, rd);
      regs[3] = b;
      regs[7] = a | b;
      sh = 0;
      drv = 0;
      for (k = 0; k < 100; k++) begin
        @(negedge clk_in);
        if (pcs_bus_if_inst.pcm_oe_n[0] === 1'b0) begin
          sh = {sh[30:0], pcs_bus_if_inst.pcm_output[0]};
          drv++;
        end
        if (pcs_bus_if_inst.pcm_oe_n[7:1] !== 7'h7f) drv = drv + 1000;
      end
      for (k = 31; k >= 0; k--) exp_sh[k] = regs[7][k / 4];
      check("pcm bits driven", 8'd32, 8'(drv < 256 ? drv : 255));
      check("pcm serial hi", exp_sh[31:24], sh[31:24]);
      check("pcm serial lo", exp_sh[7:0], sh[7:0]);
      // summing path: two loud samples saturate and raise overflow
      op(1'b1, 8'h00, 8'h01);
      op(1'b1, 8'h02, 8'h70);
      access(1'b1, 8'h03, 8'h70, rd);
      regs[3] = 8'h70;
      regs[7] = 8'(SAT_MAX);
      regs[1] = 1 << STAT_OVF;
      repeat (40) @(negedge clk_in);
      check("irq", 8'h01, {7'h00, irq_out});
      for (k = 0; k < 8; k++) op(1'b0, k[7:0], 8'h00);
      op(1'b1, 8'h01, 8'h01);
      regs[1] = 0;
      repeat (8) @(negedge clk_in);
      check("irq", 8'h00, {7'h00, irq_out});
      op(1'b0, 8'h01, 8'h00);
      op(1'b1, 8'h00, 8'h25);
      for (k = 0; k < 8; k++) op(1'b0, k[7:0], 8'h00);
      // conference numbers 20 and 22, read-only result, reserved address when multiplexed
      for (k = 0; k < 4; k++) begin
        a = m[0] ? (k == 2 ? 8'h07 : 8'h05) : (k == 2 ? 8'h03 : 8'h01);
        if (k == 3) a = m[0] ? 8'h0d : 8'h01;
        op(1'b1, a, k == 0 ? 8'd20 : 8'(MAX_CONF + k));
        op(1'b0, m[0] ? (k == 2 ? 8'h07 : 8'h05) : a, 8'h00);
      end
      for (k = 0; k < 40; k++) begin
        a = ($urandom % 8 == 0) ? 8'($urandom) : 8'($urandom % 8);
        op(1'($urandom), a, 8'($urandom));
      end
      check("irq", 8'h00, {7'h00, irq_out});
      $display("mode %0d done, checks %0d, fails %0d", m, n_checks, fails);
    end
    end_sim();
  end
endmodule
